// *** rtl/lufs_sequencer.sv ***
/*
 * Line undervoltage and thermal fault sequencer: decides switching
 * permission, drives the sense test current, supply recycling and the
 * peak-current jitter square wave, with an APB register slave.
 * Assumes comparator levels arrive asynchronously and APB is on clk_in.
 */
// Design decisions made here: the APB interface to the registers and the placing of the registers.
//
// Function
// - While the supply charges to its on threshold, source the sense test current and watch the pin.
// - A sense level below the disable threshold then latches the line function off until power-on and starts up.
// - Otherwise start and switch for a fixed window, then keep switching only above the off threshold.
// - When disabled, resume once the level stays above the on threshold longer than the recover delay.
// - When switching, stop once the level stays below the off threshold longer than the loss delay.
// - Both delays use up/down counters so short excursions change nothing.
// - Produce a fixed-frequency square wave with equal high and low halves for current-limit jitter.
// - The jitter depth defaults to a fixed percentage of the limit amplitude.
// - Over-temperature stops switching for the restart time, then restarts when supply reaches on.
// - During the restart time recycle the supply between its thresholds and enter reduced consumption.
`timescale 1ns/1ps
module lufs_sequencer import lufs_pkg::*; #(
  parameter int unsigned STARTUP_WINDOW_CYCLES = STARTUP_WINDOW_CYC,
  parameter int unsigned RECOVER_CYCLES = RECOVER_DELAY_CYC,
  parameter int unsigned LOSS_CYCLES = LOSS_DELAY_CYC,
  parameter int unsigned RESTART_CYCLES = RESTART_TIME_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire lufs_cmp_type cmp_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic switch_enable_out,
  output logic sense_test_current_out,
  output logic hv_source_enable_out,
  output logic fault_low_power_out,
  output logic jitter_out,
  output logic [7:0] jitter_depth_out,
  output logic irq_out
);

  lufs_cmp_type meta_r;
  lufs_cmp_type cmp_r;
  lufs_state_type state_r;
  lufs_state_type state_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic bypass_r;
  logic bypass_nxt;
  logic loss_done;
  logic recover_done;
  logic [IRQ_W-1:0] event_set;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic jit_en_r;
  logic [7:0] depth_r;
  logic [JITTER_CNT_W-1:0] jit_cnt_r;
  logic jit_wave_r;
  logic access;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_hit;
  logic hot_trip;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_clear;

  function automatic logic is_switching(input lufs_state_type st);
    return (st == ST_WINDOW) || (st == ST_RUN);
  endfunction

  // Shared timer compare; len counts whole cycles in the state
  function automatic logic timer_at_end(input logic [TIMER_W-1:0] t,
                                        input int unsigned len);
    return t == TIMER_W'(len - 1);
  endfunction

  // Full 12-bit compare, so aliases above the map answer as errors
  function automatic logic is_reg(input logic [11:0] a,
                                  input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // Comparator synchroniser; first stage read only by second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      cmp_r <= '0;
    end else begin
      meta_r <= cmp_in;
      cmp_r <= meta_r;
    end
  end

  // Counters clear outside their own state, so each delay starts fresh
  lufs_updown_cnt #(
    .LIMIT(LOSS_CYCLES)
  ) u_loss_cnt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(state_r != ST_RUN),
    .up_in(!cmp_r.above_off),
    .done_out(loss_done)
  );

  lufs_updown_cnt #(
    .LIMIT(RECOVER_CYCLES)
  ) u_recover_cnt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(state_r != ST_LINE_OFF),
    .up_in(cmp_r.above_on),
    .done_out(recover_done)
  );

  // Power-up is left out: the sense check must finish before a trip
  assign hot_trip = cmp_r.overtemp && state_r != ST_POWERUP &&
    state_r != ST_THERMAL && state_r != ST_WAIT_SUPPLY;

  // Sequencing decisions
  always_comb begin
    state_nxt = state_r;
    bypass_nxt = bypass_r;
    event_set = '0;
    unique case (state_r)
      ST_POWERUP: begin
        if (cmp_r.supply_on) begin
          if (!cmp_r.above_disable) begin
            bypass_nxt = 1'b1;
            event_set[IRQ_BYPASS] = 1'b1;
            state_nxt = ST_RUN;
          end else begin
            state_nxt = ST_WINDOW;
          end
        end
      end
      ST_WINDOW: begin
        if (timer_at_end(timer_r, STARTUP_WINDOW_CYCLES)) begin
          if (cmp_r.above_off) begin
            state_nxt = ST_RUN;
          end else begin
            state_nxt = ST_LINE_OFF;
            event_set[IRQ_BROWNOUT] = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (!bypass_r && loss_done) begin
          state_nxt = ST_LINE_OFF;
          event_set[IRQ_BROWNOUT] = 1'b1;
        end
      end
      ST_LINE_OFF: begin
        if (recover_done) begin
          state_nxt = ST_RUN;
          event_set[IRQ_BROWNIN] = 1'b1;
        end
      end
      ST_THERMAL: begin
        if (timer_at_end(timer_r, RESTART_CYCLES)) begin
          state_nxt = ST_WAIT_SUPPLY;
        end
      end
      ST_WAIT_SUPPLY: begin
        if (cmp_r.supply_on) begin
          // Line qualification resumes through the loss counter
          state_nxt = ST_RUN;
          event_set[IRQ_RESTART] = 1'b1;
        end
      end
    endcase
    // Thermal trip outranks every line decision once started
    if (hot_trip) begin
      state_nxt = ST_THERMAL;
      event_set[IRQ_THERMAL] = 1'b1;
      event_set[IRQ_BROWNOUT] = 1'b0;
      event_set[IRQ_BROWNIN] = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_POWERUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Held until the next power-on reset only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bypass_r <= 1'b0;
    end else begin
      bypass_r <= bypass_nxt;
    end
  end

  // One shared timer; restarts on every state change
  // Longer restart times need a wider TIMER_W
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || state_nxt != state_r) begin
      timer_r <= '0;
    end else if (state_r == ST_WINDOW || state_r == ST_THERMAL) begin
      timer_r <= timer_r + TIMER_W'(1);
    end
  end

  // Pin-side outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      switch_enable_out <= 1'b0;
      sense_test_current_out <= 1'b0;
      fault_low_power_out <= 1'b0;
    end else begin
      switch_enable_out <= is_switching(state_nxt);
      sense_test_current_out <= (state_nxt == ST_POWERUP);
      fault_low_power_out <= (state_nxt == ST_THERMAL);
    end
  end

  // Supply recycling: charge below off threshold, stop at on threshold
  // Between the two levels the source keeps its last state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hv_source_enable_out <= 1'b0;
    end else if (state_r == ST_POWERUP) begin
      hv_source_enable_out <= !cmp_r.supply_on;
    end else if (state_r == ST_THERMAL || state_r == ST_WAIT_SUPPLY) begin
      if (cmp_r.supply_on) begin
        hv_source_enable_out <= 1'b0;
      end else if (!cmp_r.supply_above_off) begin
        hv_source_enable_out <= 1'b1;
      end
    end else begin
      hv_source_enable_out <= 1'b0;
    end
  end

  // Jitter square wave, free running
  // Free running keeps the phase when jitter is switched back on
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      jit_cnt_r <= '0;
      jit_wave_r <= 1'b0;
    end else if (jit_cnt_r == JITTER_CNT_W'(JITTER_HALF_CYC - 1)) begin
      jit_cnt_r <= '0;
      jit_wave_r <= !jit_wave_r;
    end else begin
      jit_cnt_r <= jit_cnt_r + JITTER_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      jitter_out <= 1'b0;
      jitter_depth_out <= 8'h00;
    end else begin
      jitter_out <= jit_en_r & jit_wave_r;
      jitter_depth_out <= jit_en_r ? depth_r : 8'h00;
    end
  end

  // APB slave: one wait state, answer registered
  assign access = psel_in && penable_in && !pready_out;
  // Writes land at the edge that completes the access
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
  assign wr_ctrl = wr_en && is_reg(paddr_in, CTRL_OFS);
  assign wr_mask = wr_en && is_reg(paddr_in, IRQ_MASK_OFS);
  assign wr_clear = wr_en && is_reg(paddr_in, IRQ_STATUS_OFS);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr_in)
      CTRL_OFS: begin
        rd_data[CTRL_JIT_EN_BIT] = jit_en_r;
        rd_data[CTRL_DEPTH_LSB +: 8] = depth_r;
      end
      STATUS_OFS: begin
        // Live view, nothing latched; writes here are dropped
        rd_data[2:0] = state_r;
        rd_data[3] = bypass_r;
        rd_data[4] = switch_enable_out;
        rd_data[5] = hv_source_enable_out;
        rd_data[6] = jit_wave_r;
        rd_data[13:8] = cmp_r;
      end
      IRQ_STATUS_OFS: rd_data[IRQ_W-1:0] = irq_status_r;
      IRQ_MASK_OFS: rd_data[IRQ_W-1:0] = irq_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      // Unmapped addresses answer with an error and zero data
      pready_out <= access;
      pslverr_out <= access && !rd_hit;
      prdata_out <= (access && !pwrite_in) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      jit_en_r <= CTRL_JIT_EN_RST;
      depth_r <= JITTER_DEPTH_RST;
    end else if (wr_ctrl) begin
      jit_en_r <= pwdata_in[CTRL_JIT_EN_BIT];
      depth_r <= pwdata_in[CTRL_DEPTH_LSB +: 8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_r <= pwdata_in[IRQ_W-1:0];
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_status_r <= IRQ_RST;
    end else if (wr_clear) begin
      irq_status_r <= (irq_status_r & ~pwdata_in[IRQ_W-1:0]) | event_set;
    end else begin
      irq_status_r <= irq_status_r | event_set;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      // One cycle behind the status, so the pin never glitches
      irq_out <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule

// *** rtl/lufs_pkg.sv ***
/*
 * Constants, register map and types shared by the line undervoltage and
 * thermal fault sequencer.
 * Assumes a single 50 MHz clock and a 32-bit APB register port.
 */
package lufs_pkg;

  // Clock rate and derived cycle scale
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Times in their own units, then cycle counts
  localparam int unsigned STARTUP_WINDOW_MS = 30;
  localparam int unsigned STARTUP_WINDOW_CYC =
    STARTUP_WINDOW_MS * 1000 * CYC_PER_US;
  localparam int unsigned RECOVER_DELAY_US = 250;
  localparam int unsigned RECOVER_DELAY_CYC = RECOVER_DELAY_US * CYC_PER_US;
  localparam int unsigned LOSS_DELAY_MS = 30;
  localparam int unsigned LOSS_DELAY_CYC = LOSS_DELAY_MS * 1000 * CYC_PER_US;
  localparam int unsigned RESTART_TIME_S = 2;
  localparam int unsigned RESTART_TIME_CYC = RESTART_TIME_S * CLK_HZ;
  localparam int unsigned JITTER_FREQ_HZ = 10_000;
  // Equal high and low halves; longest time, so rounds down
  localparam int unsigned JITTER_HALF_CYC = CLK_HZ / (2 * JITTER_FREQ_HZ);
  localparam int unsigned JITTER_CNT_W = 12;
  localparam int unsigned TIMER_W = 27;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;

  // Control fields and reset values
  localparam int unsigned CTRL_JIT_EN_BIT = 0;
  localparam int unsigned CTRL_DEPTH_LSB = 8;
  localparam logic CTRL_JIT_EN_RST = 1'b1;
  localparam logic [7:0] JITTER_DEPTH_RST = 8'h05;

  // Interrupt event bits
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_BROWNOUT = 0;
  localparam int unsigned IRQ_BROWNIN = 1;
  localparam int unsigned IRQ_THERMAL = 2;
  localparam int unsigned IRQ_RESTART = 3;
  localparam int unsigned IRQ_BYPASS = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic above_disable;
    logic above_off;
    logic above_on;
    logic supply_on;
    logic supply_above_off;
    logic overtemp;
  } lufs_cmp_type;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_WINDOW,
    ST_RUN,
    ST_LINE_OFF,
    ST_THERMAL,
    ST_WAIT_SUPPLY
  } lufs_state_type;

endpackage

// *** rtl/lufs_updown_cnt.sv ***
/*
 * Saturating up/down delay counter used as a qualification filter.
 * Assumes the condition input is already synchronous to clk_in.
 */
`timescale 1ns/1ps
module lufs_updown_cnt #(
  parameter int unsigned LIMIT = 12500,
  parameter int unsigned W = $clog2(LIMIT + 1)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic up_in,
  output logic done_out
);

  logic [W-1:0] count_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clear_in) begin
      count_r <= '0;
    end else if (up_in) begin
      if (count_r != W'(LIMIT)) begin
        count_r <= count_r + W'(1);
      end
    end else if (count_r != '0) begin
      // Short glitches are undone, not forgotten at once
      count_r <= count_r - W'(1);
    end
  end

  assign done_out = (count_r == W'(LIMIT));

endmodule

// *** tb/lufs_checker.sv ***
/* Port assertions for the fault sequencer.
   Assumes one clock domain and a bind to every sequencer instance. */
`timescale 1ns/1ps
module lufs_checker import lufs_pkg::*; #(
  parameter int unsigned RESTART_CYCLES = RESTART_TIME_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire lufs_cmp_type cmp_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic switch_enable_out,
  input wire logic sense_test_current_out,
  input wire logic fault_low_power_out,
  input wire logic jitter_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic jit_last_r;
  logic jit_seen_r;
  logic [11:0] jit_cnt_r;
  logic [31:0] flt_cnt_r;
  always_ff @(posedge clk_in) begin
    jit_last_r <= jitter_out;
    if (!rst_n_in) begin
      jit_cnt_r <= 12'h000;
      jit_seen_r <= 1'b0;
    end else if (jitter_out != jit_last_r) begin
      jit_cnt_r <= 12'h000;
      jit_seen_r <= 1'b1;
    end else begin
      jit_cnt_r <= jit_cnt_r + 12'h001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !fault_low_power_out) begin
      flt_cnt_r <= 32'h0;
    end else begin
      flt_cnt_r <= flt_cnt_r + 32'h1;
    end
  end
  // Two samples, so a one-cycle glitch never arms it
  sequence hot_s;
    (switch_enable_out && cmp_in.overtemp) [*2];
  endsequence
  AST_APB_ANSWER: assert property (psel_in && penable_in && !pready_out
    |=> pready_out) else $error("no ready after access");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  AST_ERR_QUAL: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside ready");
  AST_SENSE_POWERUP: assert property (
    sense_test_current_out |-> !switch_enable_out)
    else $error("switching during sense check");
  AST_FAULT_OFF: assert property (
    fault_low_power_out |-> !switch_enable_out)
    else $error("switching in fault state");
  AST_OVERTEMP_STOP: assert property (
    hot_s |-> ##[1:4] !switch_enable_out)
    else $error("switching kept when hot");
  AST_RESTART_HOLD: assert property (
    $fell(fault_low_power_out) |-> flt_cnt_r >= RESTART_CYCLES - 1)
    else $error("restart time too short");
  AST_JITTER_HALF: assert property (
    jitter_out != jit_last_r && jit_seen_r
    |-> jit_cnt_r == JITTER_HALF_CYC - 1) else $error("jitter half wrong");
endmodule

bind lufs_sequencer lufs_checker #(.RESTART_CYCLES(RESTART_CYCLES)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .cmp_in(cmp_in),
  .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .switch_enable_out(switch_enable_out),
  .sense_test_current_out(sense_test_current_out),
  .fault_low_power_out(fault_low_power_out), .jitter_out(jitter_out));

// *** tb/lufs_analog_model.sv ***
/* Comparators on the sense level and a supply capacitor model.
   Assumes the bench sets the line level in mV and the hot flag. */
`timescale 1ns/1ps
module lufs_analog_model import lufs_pkg::*; (
  input wire logic clk_in,
  input wire logic hv_source_enable_in,
  input wire logic switch_enable_in,
  input wire logic hot_in,
  input wire logic [15:0] line_mv_in,
  output lufs_cmp_type cmp_out
);
  // Not reset: the capacitor keeps its charge over a logic reset
  logic [4:0] vdd_r = 5'h00;
  always_ff @(posedge clk_in) begin
    if (hv_source_enable_in && vdd_r != 5'h14) begin
      vdd_r <= vdd_r + 5'h01;
    end else if (!hv_source_enable_in && !switch_enable_in
                 && vdd_r != 5'h00) begin
      vdd_r <= vdd_r - 5'h01;
    end
  end
  always_comb begin
    cmp_out.above_disable = line_mv_in > 16'h0064;
    cmp_out.above_off = line_mv_in > 16'h0190;
    cmp_out.above_on = line_mv_in > 16'h01F4;
    cmp_out.supply_on = vdd_r == 5'h14;
    cmp_out.supply_above_off = vdd_r > 5'h07;
    cmp_out.overtemp = hot_in;
  end
endmodule

// *** tb/tb_top.sv ***
/* Self-checking bench for the fault sequencer, short count parameters.
   Assumes the analog model on the comparator side and APB tasks. */
`timescale 1ns/1ps
module tb_top import lufs_pkg::*;;
  logic clk_in = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic hot = 1'b0;
  logic [15:0] line_mv = 16'h0000;
  lufs_cmp_type cmp;
  logic [31:0] prdata, rd;
  logic pready, perr, err, sw, sense, hv, flt, jit, irq;
  logic [7:0] depth;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int hv_rises = 0;
  logic hv_last = 1'b0;
  int n;
  lufs_sequencer #(.STARTUP_WINDOW_CYCLES(200), .RECOVER_CYCLES(50),
    .LOSS_CYCLES(200), .RESTART_CYCLES(300)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n), .cmp_in(cmp), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .switch_enable_out(sw),
    .sense_test_current_out(sense), .hv_source_enable_out(hv),
    .fault_low_power_out(flt), .jitter_out(jit),
    .jitter_depth_out(depth), .irq_out(irq));
  lufs_analog_model u_ana (.clk_in(clk_in), .hv_source_enable_in(hv),
    .switch_enable_in(sw), .hot_in(hot), .line_mv_in(line_mv),
    .cmp_out(cmp));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (hv === 1'b1 && hv_last === 1'b0) hv_rises++;
    hv_last <= hv;
    if (cyc == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) num_errors++;
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  // Cycles until the switch (sel 0) or jitter (sel 1) shows want
  task automatic wt(input bit sel, input logic want);
    n = 0;
    while ((sel ? jit : sw) !== want && n < 6000) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 6000) num_errors++;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    @(posedge clk_in);
    do_reset();
    repeat (2) @(posedge clk_in);
    chk("sense", sense, 1'b1);
    chk("sw", sw, 1'b0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h0000_0501);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    wt(0, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("bypass", rd[4:0], 5'h1A);
    line_mv <= 16'd300;
    repeat (400) @(posedge clk_in);
    chk("latched", sw, 1'b1);
    chk("depth", depth, 8'h05);
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk("jit high", n, 2500);
    wt(1, 1'b1);
    chk("jit low", n, 2500);
    $display("test bypass done");
    do_reset();
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk("window", n >= 196 && n <= 204, 1'b1);
    apb(1'b1, IRQ_MASK_OFS, 32'h2);
    line_mv <= 16'd600;
    repeat (30) @(posedge clk_in);
    line_mv <= 16'd300;
    repeat (40) @(posedge clk_in);
    chk("glitch", sw, 1'b0);
    line_mv <= 16'd600;
    wt(0, 1'b1);
    chk("brownin", n >= 48 && n <= 58, 1'b1);
    repeat (4) @(posedge clk_in);
    chk("irq", irq, 1'b1);
    apb(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk("irq st", rd, 32'h3);
    apb(1'b1, IRQ_STATUS_OFS, 32'h2);
    apb(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk("irq clr", {irq, rd[30:0]}, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0000_0A01);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl wr", rd, 32'h0000_0A01);
    chk("depth wr", depth, 8'h0A);
    line_mv <= 16'd300;
    wt(0, 1'b0);
    chk("brownout", n >= 196 && n <= 206, 1'b1);
    $display("test line done");
    line_mv <= 16'd600;
    wt(0, 1'b1);
    hv_rises = 0;
    hot <= 1'b1;
    wt(0, 1'b0);
    chk("hot stop", n <= 6, 1'b1);
    repeat (3) @(posedge clk_in);
    chk("low power", flt, 1'b1);
    hot <= 1'b0;
    wt(0, 1'b1);
    chk("restart", n >= 296 && n <= 360, 1'b1);
    chk("recycle", hv_rises > 1, 1'b1);
    $display("test thermal done");
    stop_test();
  end
endmodule
